// ### core/csm_pkg.sv
package csm_pkg;

  // Register byte offsets
  localparam logic [7:0] CSM_OFS_SETUP  = 8'h00;
  localparam logic [7:0] CSM_OFS_DATA   = 8'h04;
  localparam logic [7:0] CSM_OFS_LEVELS = 8'h08;
  localparam logic [7:0] CSM_OFS_SOE    = 8'h0c;
  localparam logic [7:0] CSM_OFS_LATCH  = 8'h10;
  localparam logic [7:0] CSM_OFS_DIR    = 8'h14;
  localparam logic [7:0] CSM_OFS_START  = 8'h18;
  localparam logic [7:0] CSM_OFS_STOP   = 8'h1c;
  localparam logic [7:0] CSM_OFS_STATUS = 8'h20;

  // Setup register fields
  localparam int CSM_SETUP_TXE_BIT = 15;
  localparam int CSM_SETUP_RXE_BIT = 14;
  localparam int CSM_SETUP_DIR_BIT = 7;
  localparam int CSM_SETUP_DLS_HI  = 1;
  localparam int CSM_SETUP_DLS_LO  = 0;
  localparam logic [1:0] CSM_LEN_7 = 2'b10;
  localparam logic [1:0] CSM_LEN_8 = 2'b11;

  // Data register fields
  localparam int CSM_DATA_DIV_LO = 9;
  localparam int CSM_DATA_DIV_HI = 15;

  // Line level and enable fields
  localparam int CSM_LEVEL_CLK_BIT = 8;
  localparam int CSM_LEVEL_DAT_BIT = 0;
  localparam int CSM_SOE_BIT       = 0;

  // Start, stop and status fields
  localparam int CSM_START_BIT     = 0;
  localparam int CSM_STOP_BIT      = 0;
  localparam int CSM_STAT_OPER_BIT = 8;
  localparam int CSM_STAT_TSF_BIT  = 6;

  // Port pin roles
  localparam int CSM_PIN_SCK = 0;
  localparam int CSM_PIN_SI  = 1;
  localparam int CSM_PIN_SO  = 2;

  // Values after reset
  localparam logic [15:0] CSM_RST_SETUP  = 16'h0007;
  localparam logic [15:0] CSM_RST_DATA   = 16'h0000;
  localparam logic [15:0] CSM_RST_LEVELS = 16'h0101;
  localparam logic [15:0] CSM_RST_SOE    = 16'h0000;
  localparam logic [7:0]  CSM_RST_LATCH  = 8'h00;
  localparam logic [7:0]  CSM_RST_DIR    = 8'hff;

  // Word handed to the link side at a transfer start
  typedef struct packed {
    logic [7:0] tx_data;
    logic [6:0] divider;
    logic       lsb_first;
    logic       len8;
    logic       rx_en;
  } csm_xfer_t;

  // Line state coming back from the link side
  typedef struct packed {
    logic run;
    logic sck;
    logic so;
  } csm_line_t;

endpackage

// ### core/csm_sync.sv
`timescale 1ns/100ps
module csm_sync
  import csm_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_reg;

  // Two-stage synchroniser
  always_ff @(posedge clk_i)
  begin
    meta_reg <= d_i;
    q_o      <= meta_reg;
  end

endmodule

// ### core/csm_top.sv
// Notes on behaviour
// - Bit order 0 shifts each word out and in most significant bit first.
// - Bit order 1 shifts each word out and in least significant bit first.
// - Length code 10 selects 7-bit words in data bits 6 to 0.
// - Length code 11 selects 8-bit words in data bits 7 to 0.
// - Serial clock is the operation clock divided by twice one plus the 7-bit divider.
// - Clock level bit sets the clock line while no transfer drives it.
// - Data level bit sets the data output line while no transfer drives it.
// - Output enable 1 lets the transfer drive data out, 0 leaves the set level.
// - Direction 0 turns a pin's output buffer on, 1 makes it an input.
// - A latch drives an output pin and reading an input pin returns its level.
// - Enable field 00 off, 01 receive only, 10 transmit only, 11 both.
// - Writing 1 to start sets the operating flag; start always reads zero.
// - Writing the low byte of the data register starts a transfer.
// - Status transfer flag is 1 while a transfer is in progress.
`timescale 1ns/100ps
module csm_top
  import csm_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        operation_clock_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [7:0]  port1_i,
  output logic      [7:0]  port1_o,
  output logic      [7:0]  port1_oe_o
);

  // Bus side registers
  logic [15:0] setup_reg;
  logic [15:0] data_reg;
  logic [15:0] levels_reg;
  logic [15:0] soe_reg;
  logic [7:0]  latch_reg;
  logic [7:0]  dir_reg;
  logic        oper_reg;
  logic        req_tgl_reg;
  logic        done_prev_reg;
  csm_xfer_t   xfer_reg;

  // Crossing wires
  logic [7:0]  pins_s;
  logic        done_s;
  csm_line_t   line_s;
  logic        lrst;
  logic        req_s;
  logic        si_s;

  // Link side registers
  typedef enum logic {CSM_IDLE, CSM_RUN} csm_state_t;
  csm_state_t  state_reg;
  csm_xfer_t   lx_reg;
  csm_line_t   line_reg;
  logic        req_prev_reg;
  logic        done_tgl_reg;
  logic        phase_reg;
  logic [2:0]  cnt_reg;
  logic [6:0]  div_cnt_reg;
  logic [7:0]  rx_reg;
  logic [1:0]  smp_vld_reg;
  logic [5:0]  smp_idx_reg;
  logic [1:0]  end_pipe_reg;

  logic        busy;
  logic        done_evt;
  logic        rise_evt;
  logic        end_evt;
  logic        wr_en;
  logic        rd_en;
  logic        start_xfer;
  logic [15:0] wdat;
  logic [15:0] rd_data;
  logic [2:0]  last_idx;
  logic [2:0]  cur_idx;
  logic [2:0]  nxt_idx;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [1:0]  sel);
    logic [15:0] r;
    r = old;
    if (sel[0])
      r[7:0] = nw[7:0];
    if (sel[1])
      r[15:8] = nw[15:8];
    return r;
  endfunction

  // Position of bit number n within the word
  function automatic logic [2:0] bit_pos(input logic [2:0] n,
                                         input logic       lsb,
                                         input logic       len8);
    logic [2:0] top;
    top = len8 ? 3'h7 : 3'h6;
    return lsb ? n : 3'(top - n);
  endfunction

  csm_sync #(.WIDTH(8)) u_pins_sync (
    .clk_i (clk_i),
    .d_i   (port1_i),
    .q_o   (pins_s)
  );

  csm_sync #(.WIDTH(4)) u_back_sync (
    .clk_i (clk_i),
    .d_i   ({done_tgl_reg, line_reg}),
    .q_o   ({done_s, line_s})
  );

  csm_sync #(.WIDTH(3)) u_link_sync (
    .clk_i (operation_clock_i),
    .d_i   ({rst_i, req_tgl_reg, port1_i[CSM_PIN_SI]}),
    .q_o   ({lrst, req_s, si_s})
  );

  assign busy     = req_tgl_reg != done_prev_reg;
  assign done_evt = done_s != done_prev_reg;
  assign wr_en    = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign rd_en    = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
  assign wdat     = wb_dat_i[15:0];

  assign start_xfer = wr_en & (wb_adr_i == CSM_OFS_DATA) & wb_sel_i[0] & oper_reg & ~busy &
                      (setup_reg[CSM_SETUP_TXE_BIT] | setup_reg[CSM_SETUP_RXE_BIT]);

  // Bus acknowledge, one wait state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
  end

  // Configuration registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      setup_reg  <= CSM_RST_SETUP;
      levels_reg <= CSM_RST_LEVELS;
      soe_reg    <= CSM_RST_SOE;
      latch_reg  <= CSM_RST_LATCH;
      dir_reg    <= CSM_RST_DIR;
    end
    else if (wr_en)
    begin
      unique case (wb_adr_i)
        CSM_OFS_SETUP:  setup_reg  <= merge16(setup_reg, wdat, wb_sel_i[1:0]);
        CSM_OFS_LEVELS: levels_reg <= merge16(levels_reg, wdat, wb_sel_i[1:0]);
        CSM_OFS_SOE:    soe_reg    <= merge16(soe_reg, wdat, wb_sel_i[1:0]);
        CSM_OFS_LATCH:  latch_reg  <= wb_sel_i[0] ? wdat[7:0] : latch_reg;
        CSM_OFS_DIR:    dir_reg    <= wb_sel_i[0] ? wdat[7:0] : dir_reg;
        default:        setup_reg  <= setup_reg;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      oper_reg <= 1'b0;
    else if (wr_en & (wb_adr_i == CSM_OFS_START) & wb_sel_i[0] & wdat[CSM_START_BIT])
      oper_reg <= 1'b1;
    else if (wr_en & (wb_adr_i == CSM_OFS_STOP) & wb_sel_i[0] & wdat[CSM_STOP_BIT])
      oper_reg <= 1'b0;
  end

  // Data register, held while busy
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      data_reg <= CSM_RST_DATA;
    else if (done_evt & xfer_reg.rx_en)
      data_reg[7:0] <= rx_reg;
    else if (wr_en & (wb_adr_i == CSM_OFS_DATA) & ~busy)
      data_reg <= merge16(data_reg, wdat, wb_sel_i[1:0]);
  end

  // Start handshake toward link side
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      req_tgl_reg   <= 1'b0;
      done_prev_reg <= 1'b0;
      xfer_reg      <= '0;
    end
    else
    begin
      if (done_evt)
        done_prev_reg <= done_s;
      if (start_xfer)
      begin
        req_tgl_reg       <= ~req_tgl_reg;
        xfer_reg.tx_data  <= setup_reg[CSM_SETUP_TXE_BIT] ? wdat[7:0] : 8'hff;
        xfer_reg.divider  <= wb_sel_i[1] ? wdat[CSM_DATA_DIV_HI:CSM_DATA_DIV_LO]
                                         : data_reg[CSM_DATA_DIV_HI:CSM_DATA_DIV_LO];
        xfer_reg.lsb_first <= setup_reg[CSM_SETUP_DIR_BIT];
        xfer_reg.len8     <= setup_reg[CSM_SETUP_DLS_HI:CSM_SETUP_DLS_LO] == CSM_LEN_8;
        xfer_reg.rx_en    <= setup_reg[CSM_SETUP_RXE_BIT];
      end
    end
  end

  // Register read mux
  always_comb
  begin
    rd_data = 16'h0000;
    unique case (wb_adr_i)
      CSM_OFS_SETUP:  rd_data = setup_reg;
      CSM_OFS_DATA:   rd_data = {data_reg[15:9], 1'b0,
                                 (setup_reg[CSM_SETUP_DLS_HI:CSM_SETUP_DLS_LO] == CSM_LEN_8) &
                                 data_reg[7], data_reg[6:0]};
      CSM_OFS_LEVELS: rd_data = levels_reg;
      CSM_OFS_SOE:    rd_data = soe_reg;
      CSM_OFS_LATCH:  rd_data = {8'h00, (dir_reg & pins_s) | (~dir_reg & latch_reg)};
      CSM_OFS_DIR:    rd_data = {8'h00, dir_reg};
      CSM_OFS_STATUS: rd_data = 16'((16'(oper_reg) << CSM_STAT_OPER_BIT) |
                                    (16'(busy) << CSM_STAT_TSF_BIT));
      default:        rd_data = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (rd_en)
      wb_dat_o <= {16'h0000, rd_data};
  end

  // Pin drivers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      port1_o    <= 8'h00;
      port1_oe_o <= 8'h00;
    end
    else
    begin
      port1_oe_o <= ~dir_reg;
      port1_o    <= latch_reg;
      port1_o[CSM_PIN_SCK] <= latch_reg[CSM_PIN_SCK] &
                              (line_s.run ? line_s.sck : levels_reg[CSM_LEVEL_CLK_BIT]);
      port1_o[CSM_PIN_SO]  <= latch_reg[CSM_PIN_SO] &
                              ((line_s.run & soe_reg[CSM_SOE_BIT] & setup_reg[CSM_SETUP_TXE_BIT])
                               ? line_s.so : levels_reg[CSM_LEVEL_DAT_BIT]);
    end
  end

  // Link side shift engine
  assign last_idx = lx_reg.len8 ? 3'h7 : 3'h6;
  assign cur_idx  = bit_pos(cnt_reg, lx_reg.lsb_first, lx_reg.len8);
  assign nxt_idx  = bit_pos(3'(cnt_reg + 3'h1), lx_reg.lsb_first, lx_reg.len8);
  assign rise_evt = (state_reg == CSM_RUN) & (div_cnt_reg == lx_reg.divider) & ~phase_reg;
  assign end_evt  = (state_reg == CSM_RUN) & (div_cnt_reg == lx_reg.divider) & phase_reg &
                    (cnt_reg == last_idx);

  always_ff @(posedge operation_clock_i)
  begin
    if (lrst)
    begin
      state_reg    <= CSM_IDLE;
      lx_reg       <= '0;
      line_reg     <= '0;
      req_prev_reg <= 1'b0;
      phase_reg    <= 1'b0;
      cnt_reg      <= 3'h0;
      div_cnt_reg  <= 7'h00;
    end
    else
    begin
      unique case (state_reg)
        CSM_IDLE:
        begin
          if (req_s != req_prev_reg)
          begin
            req_prev_reg <= req_s;
            lx_reg       <= xfer_reg;
            state_reg    <= CSM_RUN;
            cnt_reg      <= 3'h0;
            div_cnt_reg  <= 7'h00;
            phase_reg    <= 1'b0;
            line_reg.run <= 1'b1;
            line_reg.sck <= 1'b0;
            line_reg.so  <= xfer_reg.tx_data[bit_pos(3'h0, xfer_reg.lsb_first, xfer_reg.len8)];
          end
        end
        CSM_RUN:
        begin
          // half period of divider plus one
          if (div_cnt_reg == lx_reg.divider)
          begin
            div_cnt_reg <= 7'h00;
            phase_reg   <= ~phase_reg;
            if (!phase_reg)
            begin
              line_reg.sck <= 1'b1;
            end
            else if (cnt_reg == last_idx)
            begin
              state_reg    <= CSM_IDLE;
              line_reg.run <= 1'b0;
            end
            else
            begin
              line_reg.sck <= 1'b0;
              line_reg.so  <= lx_reg.tx_data[nxt_idx];
              cnt_reg      <= 3'(cnt_reg + 3'h1);
            end
          end
          else
            div_cnt_reg <= 7'(div_cnt_reg + 7'h01);
        end
      endcase
    end
  end

  // Input sampled two cycles late to match its synchroniser
  always_ff @(posedge operation_clock_i)
  begin
    if (lrst)
    begin
      smp_vld_reg  <= 2'b00;
      smp_idx_reg  <= 6'h00;
      end_pipe_reg <= 2'b00;
      done_tgl_reg <= 1'b0;
      rx_reg       <= 8'h00;
    end
    else
    begin
      smp_vld_reg  <= {smp_vld_reg[0], rise_evt & lx_reg.rx_en};
      smp_idx_reg  <= {smp_idx_reg[2:0], cur_idx};
      end_pipe_reg <= {end_pipe_reg[0], end_evt};
      if (end_pipe_reg[1])
        done_tgl_reg <= ~done_tgl_reg;
      if (smp_vld_reg[1])
        rx_reg[smp_idx_reg[5:3]] <= si_s;
    end
  end

endmodule

// ### tb/csm_monitor.sv
`timescale 1ns/100ps
module csm_monitor
  import csm_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        operation_clock_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [7:0]  port1_i,
  input wire logic [7:0]  port1_o,
  input wire logic [7:0]  port1_oe_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  wire rd_acc = wb_ack_o && !wb_we_i;
  wire wr_acc = wb_ack_o && wb_we_i && wb_sel_i[0];
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over one cycle");
  a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_start_zero: assert property (rd_acc && wb_adr_i == CSM_OFS_START |-> wb_dat_o == 32'h0)
    else $error("start register read not zero");
  a_rdata_holds: assert property (!rd_acc |-> $stable(wb_dat_o))
    else $error("read data moved outside a read");
  a_oe_dir: assert property (wr_acc && wb_adr_i == CSM_OFS_DIR |->
    ##2 port1_oe_o == ~$past(wb_dat_i[7:0], 2))
    else $error("pin enables do not follow direction");
  a_latch_out: assert property (wr_acc && wb_adr_i == CSM_OFS_LATCH |->
    ##2 port1_o[7:3] == $past(wb_dat_i[7:3], 2))
    else $error("pin outputs do not follow latch");
  a_dir_read: assert property (rd_acc && wb_adr_i == CSM_OFS_DIR |->
    wb_dat_o[7:0] == ~port1_oe_o)
    else $error("direction read disagrees with enables");
  cover property (wr_acc && wb_adr_i == CSM_OFS_DATA);
  cover property (rd_acc && wb_adr_i == CSM_OFS_STATUS && wb_dat_o[CSM_STAT_TSF_BIT]);
  cover property ($fell(port1_o[CSM_PIN_SCK]) && port1_oe_o[CSM_PIN_SCK]);
endmodule

bind csm_top csm_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i),
  .operation_clock_i(operation_clock_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port1_i(port1_i), .port1_o(port1_o),
  .port1_oe_o(port1_oe_o));

// ### tb/csm_slave_model.sv
`timescale 1ns/100ps
module csm_slave_model
(
  input  wire logic       sck_i,
  input  wire logic       so_i,
  input  wire logic       load_i,
  input  wire logic [7:0] reply_i,
  output logic            si_o,
  output logic [7:0]      rx_o
);
  logic [7:0] sh = 8'h00;
  logic       rose = 1'b0;
  assign si_o = sh[7];
  always @(posedge sck_i or posedge load_i)
    if (load_i)
      rose <= 1'b0;
    else
    begin
      rx_o <= {rx_o[6:0], so_i};
      rose <= 1'b1;
    end
  always @(negedge sck_i or posedge load_i)
    if (load_i)
      sh <= reply_i;
    else if (rose)
      sh <= {sh[6:0], ~sh[0]};
endmodule

// ### tb/testbench.sv
`timescale 1ns/100ps
module testbench
  import csm_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        lclk = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        ld = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [4:0]  ext_hi = 5'h00;
  logic [7:0]  reply = 8'h00;
  logic [31:0] rdat;
  logic        ack;
  logic [7:0]  po;
  logic [7:0]  poe;
  logic [7:0]  rx;
  logic        si;
  wire  [7:0]  pins = (poe & po) | (~poe & {ext_hi, 1'b1, si, 1'b1});
  int          mismatches = 0;
  int          n_tests = 0;
  int          rises = 0;
  realtime     t0;
  realtime     t1;

  csm_top DUT (.clk_i(clk_i), .rst_i(rst_i), .operation_clock_i(lclk), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .port1_i(pins), .port1_o(po), .port1_oe_o(poe));
  csm_slave_model slave (.sck_i(pins[0]), .so_i(pins[2]), .load_i(ld), .reply_i(reply),
    .si_o(si), .rx_o(rx));

  initial
    forever #2 clk_i = ~clk_i;
  initial
  begin
    #8;
    forever #15 lclk = ~lclk;
  end
  always @(posedge pins[0])
  begin
    if (rises == 0) t0 = $realtime;
    if (rises == 1) t1 = $realtime;
    rises++;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
                    output logic [15:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {16'h0, d};
    do
      @(posedge clk_i);
    while (ack !== 1'b1);
    q = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  function automatic logic [7:0] ord(input logic [7:0] v, input int n, input logic lsb);
    logic [7:0] r;
    r = 8'h00;
    for (int k = 0; k < n; k++)
      r[k] = lsb ? v[n-1-k] : v[k];
    return r;
  endfunction

  task automatic t_regs;
    logic [7:0]  ra[8] = '{CSM_OFS_SETUP, CSM_OFS_LEVELS, CSM_OFS_SOE, CSM_OFS_DIR,
                           CSM_OFS_START, CSM_OFS_STOP, CSM_OFS_DATA, 8'h24};
    logic [15:0] rv[8] = '{16'h0007, 16'h0101, 16'h0, 16'h00ff, 16'h0, 16'h0, 16'h0, 16'h0};
    logic [15:0] q;
    for (int k = 0; k < 8; k++)
    begin
      wb(1'b0, ra[k], 16'h0, q);
      chk("reset value", rv[k], q);
    end
    chk("reset enables", 16'h0, {8'h0, poe});
  endtask

  task automatic t_port;
    logic [15:0] q;
    wb(1'b1, CSM_OFS_DIR, 16'h00fa, q);
    wb(1'b1, CSM_OFS_LATCH, 16'h0005, q);
    ext_hi <= 5'h15;
    repeat (4) @(posedge clk_i);
    chk("enables", 16'h0005, {8'h0, poe});
    chk("out pins", 16'h0005, {13'h0, po[2:0]});
    wb(1'b0, CSM_OFS_LATCH, 16'h0, q);
    chk("pin read", 16'h00a8, q & 16'h00f8);
  endtask

  task automatic t_levels(input logic [15:0] lv, input logic [15:0] e);
    logic [15:0] q;
    wb(1'b1, CSM_OFS_LEVELS, lv, q);
    repeat (12) @(posedge clk_i);
    chk("line levels", e, {14'h0, pins[2], pins[0]});
  endtask

  task automatic t_xfer(input logic [1:0] md, input logic lsb, input logic l8,
                        input logic [6:0] dv, input logic [7:0] tx, input logic [7:0] rp,
                        input logic soe);
    int          n;
    int          p;
    logic [7:0]  m;
    logic [15:0] q;
    n = l8 ? 8 : 7;
    m = 8'hff >> (8 - n);
    reply = rp;
    ld = 1'b1;
    #1 ld = 1'b0;
    wb(1'b1, CSM_OFS_SOE, {15'h0, soe}, q);
    wb(1'b1, CSM_OFS_SETUP, {md, 6'h0, lsb, 5'h0, (l8 ? CSM_LEN_8 : CSM_LEN_7)}, q);
    wb(1'b1, CSM_OFS_START, 16'h0001, q);
    rises = 0;
    wb(1'b1, CSM_OFS_DATA, {dv, 1'b0, tx}, q);
    wb(1'b0, CSM_OFS_STATUS, 16'h0, q);
    chk("busy status", 16'h0140, q & 16'h0140);
    while (q[6] !== 1'b0)
      wb(1'b0, CSM_OFS_STATUS, 16'h0, q);
    repeat (12) @(posedge clk_i);
    chk("clock count", 16'(n), 16'(rises));
    p = int'(t1 - t0);
    if (p - 60 * (dv + 1) <= 8 && 60 * (dv + 1) - p <= 8) p = 60 * (dv + 1);
    chk("clock period", 16'(60 * (dv + 1)), 16'(p));
    chk("sent word", {8'h0, (md[1] && soe) ? ord(tx, n, lsb) : m}, {8'h0, rx & m});
    wb(1'b0, CSM_OFS_DATA, 16'h0, q);
    if (md[0])
      chk("received word", {8'h0, ord(rp >> (8 - n), n, lsb)}, {8'h0, q[7:0]});
  endtask

  task automatic t_off;
    logic [15:0] q;
    wb(1'b1, CSM_OFS_STOP, 16'h0001, q);
    wb(1'b1, CSM_OFS_SETUP, {14'h0, CSM_LEN_8}, q);
    wb(1'b1, CSM_OFS_START, 16'h0001, q);
    rises = 0;
    wb(1'b1, CSM_OFS_DATA, 16'h00aa, q);
    repeat (100) @(posedge clk_i);
    wb(1'b0, CSM_OFS_STATUS, 16'h0, q);
    chk("idle status", 16'h0100, q & 16'h0140);
    chk("idle clocks", 16'h0, 16'(rises));
  endtask

  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_port;
    t_levels(16'h0000, 16'h0000);
    t_levels(16'h0101, 16'h0003);
    t_xfer(2'b11, 1'b0, 1'b1, 7'd0, 8'ha5, 8'h3c, 1'b1);
    t_xfer(2'b11, 1'b1, 1'b0, 7'd3, 8'h4b, 8'hd2, 1'b1);
    t_xfer(2'b10, 1'b0, 1'b1, 7'd1, 8'h96, 8'h00, 1'b1);
    t_xfer(2'b01, 1'b1, 1'b1, 7'd0, 8'h00, 8'h81, 1'b1);
    t_xfer(2'b11, 1'b0, 1'b1, 7'd2, 8'h5a, 8'hc3, 1'b0);
    t_off;
    report_and_stop;
  end

  initial
  begin
    #100000;
    mismatches++;
    report_and_stop;
  end
endmodule
